// ---- shared/dss_pkg.sv ----
// Package of constants and types for the decimal-unit state save and restore block
`default_nettype none
package dss_pkg;
  // Instruction word layout
  localparam int          INSN_W         = 24;
  localparam int          OPC_LSB        = 18;
  localparam int          SUB_LSB        = 15;
  localparam logic [5:0]  OPC_STATE      = 6'h38;  // Octal 70
  localparam logic [2:0]  SUB_LOAD       = 3'h6;
  localparam logic [2:0]  SUB_STORE      = 3'h7;
  localparam int          ADDR_W         = 15;
  // State word layout
  localparam int          WORD_W         = 24;
  localparam int          CC_LSB         = 0;
  localparam int          DEBCRED_BIT    = 2;
  localparam int          ZSUP_BIT       = 3;
  localparam int          FLOAT_BIT      = 4;
  localparam int          FCUR_BIT       = 5;
  localparam int          FPLUS_BIT      = 6;
  localparam int          FSTAR_BIT      = 7;
  localparam int          FFLT_BIT       = 8;
  localparam int          ZERO_BIT       = 9;
  localparam int          SIGN_BIT       = 10;
  localparam int          INTR_BIT       = 11;
  localparam int          CNT_LSB        = 12;
  localparam int          CNT_W          = 12;
  // Condition codes
  localparam logic [1:0]  CC_EQUAL       = 2'h0;
  localparam logic [1:0]  CC_FIRST_GT    = 2'h1;
  localparam logic [1:0]  CC_FIRST_LT    = 2'h2;
  // Reset values
  localparam logic [1:0]  CC_RESET       = 2'h0;
  localparam logic [9:0]  FLAGS_RESET    = 10'h000;
  localparam logic [11:0] CNT_RESET      = 12'h000;
  // Interrupt status bit positions
  localparam int          EV_LOAD        = 0;
  localparam int          EV_STORE       = 1;
  localparam int          EV_TRAP        = 2;
  localparam int          EV_W           = 3;
  // Register indices
  localparam logic [1:0]  REG_STATUS     = 2'h0;
  localparam logic [1:0]  REG_MASK       = 2'h1;
  localparam logic [1:0]  REG_STATE      = 2'h2;
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [7:0]  MASK_RESET     = 8'h00;

  typedef enum logic [1:0] {
    DSS_IDLE  = 2'b00,
    DSS_READ  = 2'b01,
    DSS_WRITE = 2'b11,
    DSS_DONE  = 2'b10
  } dss_state_t;
endpackage : dss_pkg
`default_nettype wire

// ---- hw/dss_decode.sv ----
// Instruction decoder for the load-state and store-state instructions
`default_nettype none
module dss_decode (
  input  wire logic [23:0] insn,
  input  wire logic        enable_sw,
  input  wire logic        monitor,
  output logic             is_load,
  output logic             is_store,
  output logic             do_exec,
  output logic             do_trap,
  output logic             do_noop,
  output logic [14:0]      addr
);
  logic hit;

  // Opcode and sub-code match; address taken as is with no indexing
  always_comb begin
    hit      = insn[23:dss_pkg::OPC_LSB] == dss_pkg::OPC_STATE;
    is_load  = hit && insn[17:dss_pkg::SUB_LSB] == dss_pkg::SUB_LOAD;
    is_store = hit && insn[17:dss_pkg::SUB_LSB] == dss_pkg::SUB_STORE;
    addr     = insn[dss_pkg::ADDR_W-1:0];
    do_exec  = (is_load || is_store) && enable_sw;
    do_trap  = (is_load || is_store) && !enable_sw && !monitor;
    do_noop  = (is_load || is_store) && !enable_sw && monitor;
  end
endmodule : dss_decode
`default_nettype wire

// ---- hw/dss_top.sv ----
// Decimal-unit state save and restore: load-state and store-state execution
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`default_nettype none
module dss_top (
  input  wire logic        SYS_CLK,
  input  wire logic        SRST,
  // Instruction issue
  input  wire logic        INSN_VALID,
  input  wire logic [23:0] INSN_WORD,
  input  wire logic        ENABLE_SWITCH,
  input  wire logic        MONITOR_STATE,
  output logic             INSN_DONE,
  output logic             INSN_TRAP,
  output logic             BUSY,
  // Storage port
  output logic             STO_RD,
  output logic             STO_WR,
  output logic [14:0]      STO_ADDR,
  output logic [23:0]      STO_WDATA,
  input  wire logic        STO_ACK,
  input  wire logic [23:0] STO_RDATA,
  // Arithmetic side updates of the live state
  input  wire logic        UPD_VALID,
  input  wire logic [1:0]  UPD_CC,
  input  wire logic [9:0]  UPD_FLAGS,
  input  wire logic [11:0] UPD_COUNT,
  // Live state to the decimal unit
  output logic [1:0]       DEC_CC,
  output logic [9:0]       DEC_FLAGS,
  output logic [11:0]      DEC_COUNT,
  output logic             RESUME,
  // Register port
  input  wire logic [1:0]  REG_ADDR,
  input  wire logic [23:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [23:0]      REG_RDATA,
  output logic             IRQ
);
  typedef struct packed {
    dss_pkg::dss_state_t fsm;
    logic                is_load;
    logic [14:0]         addr;
    logic                sto_rd;
    logic                sto_wr;
    logic [23:0]         wdata;
    logic [1:0]          cc;
    logic [9:0]          flags;
    logic [11:0]         count;
    logic                resume;
    logic                done;
    logic                trap;
    logic [2:0]          status;
    logic [2:0]          mask;
    logic [23:0]         rdata;
  } dss_regs_t;

  dss_regs_t   st_reg;
  dss_regs_t   st_next;
  logic        dec_load;
  logic        dec_store;
  logic        dec_exec;
  logic        dec_trap;
  logic        dec_noop;
  logic [14:0] dec_addr;
  logic [23:0] image;
  logic [2:0]  ev;

  dss_decode u_decode (
    .insn      (INSN_WORD),
    .enable_sw (ENABLE_SWITCH),
    .monitor   (MONITOR_STATE),
    .is_load   (dec_load),
    .is_store  (dec_store),
    .do_exec   (dec_exec),
    .do_trap   (dec_trap),
    .do_noop   (dec_noop),
    .addr      (dec_addr)
  );

  // Live conditions packed into the shared word layout
  // Bits 6..8 hold edit forcing or compare results; one storage serves both
  assign image = {st_reg.count,
                  st_reg.flags,
                  st_reg.cc};

  // Next-state logic for the instruction sequencer, live state and registers
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    st_next.trap = 1'b0;
    ev           = 3'h0;
    case (st_reg.fsm)
      dss_pkg::DSS_IDLE: begin
        if (INSN_VALID && dec_exec) begin
          st_next.is_load = dec_load;
          st_next.addr    = dec_addr;
          if (dec_load) begin
            st_next.sto_rd = 1'b1;
            st_next.fsm    = dss_pkg::DSS_READ;
          end else if (dec_store) begin
            st_next.sto_wr = 1'b1;
            st_next.wdata  = image;
            st_next.fsm    = dss_pkg::DSS_WRITE;
          end
        end else if (INSN_VALID && dec_trap) begin
          st_next.trap  = 1'b1;
          ev[dss_pkg::EV_TRAP] = 1'b1;
        end else if (INSN_VALID && dec_noop) begin
          st_next.done = 1'b1;
        end else if (UPD_VALID) begin
          // Arithmetic side may only update while idle and no state instruction is offered
          st_next.cc     = UPD_CC;
          st_next.flags  = UPD_FLAGS;
          st_next.count  = UPD_COUNT;
          st_next.resume = 1'b0;
        end
      end
      dss_pkg::DSS_READ: begin
        if (STO_ACK) begin
          st_next.sto_rd = 1'b0;
          st_next.cc     = STO_RDATA[dss_pkg::CC_LSB +: 2];
          st_next.flags  = STO_RDATA[dss_pkg::DEBCRED_BIT +: 10];
          st_next.count  = STO_RDATA[dss_pkg::CNT_LSB +: dss_pkg::CNT_W];
          st_next.resume = STO_RDATA[dss_pkg::INTR_BIT];
          ev[dss_pkg::EV_LOAD] = 1'b1;
          st_next.fsm    = dss_pkg::DSS_DONE;
        end
      end
      dss_pkg::DSS_WRITE: begin
        // Live state is untouched while storing
        if (STO_ACK) begin
          st_next.sto_wr = 1'b0;
          ev[dss_pkg::EV_STORE] = 1'b1;
          st_next.fsm    = dss_pkg::DSS_DONE;
        end
      end
      dss_pkg::DSS_DONE: begin
        st_next.done = 1'b1;
        st_next.fsm  = dss_pkg::DSS_IDLE;
      end
      default: begin
        st_next.fsm = dss_pkg::DSS_IDLE;
      end
    endcase

    // Register writes; a new event wins over a write-one clear
    if (REG_WR && REG_ADDR == dss_pkg::REG_STATUS) begin
      st_next.status = (st_reg.status & ~REG_WDATA[2:0]) | ev;
    end else begin
      st_next.status = st_reg.status | ev;
    end
    if (REG_WR && REG_ADDR == dss_pkg::REG_MASK) begin
      st_next.mask = REG_WDATA[2:0];
    end

    // Read data stands one cycle after the strobe
    st_next.rdata = 24'h000000;
    if (REG_RD) begin
      if (REG_ADDR == dss_pkg::REG_STATUS) begin
        st_next.rdata = {21'h000000, st_reg.status};
      end else if (REG_ADDR == dss_pkg::REG_MASK) begin
        st_next.rdata = {21'h000000, st_reg.mask};
      end else if (REG_ADDR == dss_pkg::REG_STATE) begin
        st_next.rdata = image;
      end else begin
        st_next.rdata = 24'h000000;
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      st_reg        <= '0;
      st_reg.fsm    <= dss_pkg::DSS_IDLE;
      st_reg.cc     <= dss_pkg::CC_RESET;
      st_reg.flags  <= dss_pkg::FLAGS_RESET;
      st_reg.count  <= dss_pkg::CNT_RESET;
      st_reg.status <= dss_pkg::STATUS_RESET[2:0];
      st_reg.mask   <= dss_pkg::MASK_RESET[2:0];
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign INSN_DONE = st_reg.done;
  assign INSN_TRAP = st_reg.trap;
  assign BUSY      = st_reg.fsm != dss_pkg::DSS_IDLE;
  assign STO_RD    = st_reg.sto_rd;
  assign STO_WR    = st_reg.sto_wr;
  assign STO_ADDR  = st_reg.addr;
  assign STO_WDATA = st_reg.wdata;
  assign DEC_CC    = st_reg.cc;
  assign DEC_FLAGS = st_reg.flags;
  assign DEC_COUNT = st_reg.count;
  assign RESUME    = st_reg.resume;
  assign REG_RDATA = st_reg.rdata;
  assign IRQ       = |(st_reg.status & st_reg.mask);
endmodule : dss_top
`default_nettype wire

// ---- tb/dss_properties.sv ----
// Concurrent checker for the state save and restore block, bound to its top
`default_nettype none
module dss_checker (
  input wire logic        SYS_CLK,
  input wire logic        SRST,
  input wire logic        INSN_VALID,
  input wire logic [23:0] INSN_WORD,
  input wire logic        ENABLE_SWITCH,
  input wire logic        MONITOR_STATE,
  input wire logic        INSN_DONE,
  input wire logic        INSN_TRAP,
  input wire logic        BUSY,
  input wire logic        STO_RD,
  input wire logic        STO_WR,
  input wire logic [14:0] STO_ADDR,
  input wire logic [23:0] STO_WDATA,
  input wire logic        STO_ACK,
  input wire logic [23:0] STO_RDATA,
  input wire logic [1:0]  DEC_CC,
  input wire logic [9:0]  DEC_FLAGS,
  input wire logic [11:0] DEC_COUNT,
  input wire logic        RESUME
);
  timeunit 1ns;
  timeprecision 1ps;
  // An accepted state instruction; the sub-code picks load or store
  wire logic [2:0] sub = INSN_WORD[17:15];
  wire logic take = INSN_VALID && !BUSY && INSN_WORD[23:18] == dss_pkg::OPC_STATE
    && (sub == dss_pkg::SUB_LOAD || sub == dss_pkg::SUB_STORE);
  wire logic rd_ack = STO_RD && STO_ACK;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  property p_trap; take && !ENABLE_SWITCH && !MONITOR_STATE |=> INSN_TRAP && !STO_RD; endproperty
  a_trap: assert property (p_trap) else $error("trap not raised");
  property p_noop;
    take && !ENABLE_SWITCH && MONITOR_STATE |=> INSN_DONE && !INSN_TRAP && !STO_RD && !STO_WR;
  endproperty
  a_noop: assert property (p_noop) else $error("no-op misbehaved");
  property p_load;
    take && ENABLE_SWITCH && sub == dss_pkg::SUB_LOAD |=> STO_RD && STO_ADDR == $past(INSN_WORD[14:0]);
  endproperty
  a_load: assert property (p_load) else $error("load request wrong");
  property p_store;
    take && ENABLE_SWITCH && sub == dss_pkg::SUB_STORE |=> STO_WR
      && STO_ADDR == $past(INSN_WORD[14:0]) && STO_WDATA == {DEC_COUNT, DEC_FLAGS, DEC_CC};
  endproperty
  a_store: assert property (p_store) else $error("store image wrong");
  property p_other; INSN_VALID && !BUSY && INSN_WORD[23:18] != dss_pkg::OPC_STATE |=> !BUSY; endproperty
  a_other: assert property (p_other) else $error("foreign opcode taken");
  property p_image; rd_ack |=> {DEC_COUNT, DEC_FLAGS, DEC_CC} == $past(STO_RDATA); endproperty
  a_image: assert property (p_image) else $error("live state not loaded");
  property p_resume; rd_ack |=> RESUME == $past(STO_RDATA[11]); endproperty
  a_resume: assert property (p_resume) else $error("resume flag wrong");
  property p_keep; STO_WR |=> $stable({DEC_COUNT, DEC_FLAGS, DEC_CC}); endproperty
  a_keep: assert property (p_keep) else $error("store disturbed state");
  property p_done; (STO_RD || STO_WR) && STO_ACK |-> ##2 INSN_DONE; endproperty
  a_done: assert property (p_done) else $error("completion late");
  c_load: cover property (rd_ack);
  c_store: cover property (STO_WR && STO_ACK);
  c_trap: cover property (INSN_TRAP);
endmodule : dss_checker
bind dss_top dss_checker u_chk (.*);
`default_nettype wire

// ---- tb/dss_storage_model.sv ----
// Behavioural core storage answering the block's read and write requests
`default_nettype none
module dss_storage_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [14:0] addr,
  input  wire logic [23:0] wdata,
  input  wire logic [3:0]  lat,
  output logic             ack,
  output logic [23:0]      rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] mem [16];
  logic [3:0]  wait_cnt;
  initial rdata = 24'hC3C3C3;
  // Answer after lat idle cycles; data toggles when not beside ack so stale reads show
  always @(posedge clk) begin
    ack   <= 1'b0;
    rdata <= ~rdata;
    if (rst) begin
      wait_cnt <= 4'h0;
    end else if ((rd || wr) && !ack) begin
      if (wait_cnt < lat) begin
        wait_cnt <= wait_cnt + 4'h1;
      end else begin
        ack      <= 1'b1;
        wait_cnt <= 4'h0;
        rdata    <= mem[addr[3:0]];
        if (wr) mem[addr[3:0]] <= wdata;
      end
    end
  end
endmodule : dss_storage_model
`default_nettype wire

// ---- tb/dss_top_test.sv ----
// Self-checking bench for the state save and restore block
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %h exp %h", $time, (a), (e)); end end
module dss_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        SYS_CLK, SRST = 1, INSN_VALID = 0, ENABLE_SWITCH = 1, MONITOR_STATE = 0;
  logic        UPD_VALID = 0, REG_WR = 0, REG_RD = 0, INSN_DONE, INSN_TRAP, BUSY;
  logic        STO_RD, STO_WR, STO_ACK, RESUME, IRQ, t, d;
  logic [23:0] INSN_WORD = 24'h0, REG_WDATA = 24'h0, STO_WDATA, STO_RDATA, REG_RDATA, rd, img;
  logic [14:0] STO_ADDR;
  logic [1:0]  UPD_CC = 2'h0, REG_ADDR = 2'h0, DEC_CC;
  logic [9:0]  UPD_FLAGS = 10'h000, DEC_FLAGS;
  logic [11:0] UPD_COUNT = 12'h000, DEC_COUNT;
  logic [3:0]  lat = 4'h0;
  int          error_cnt = 0, comparisons = 0;
  dss_top u_dut (.*);
  dss_storage_model u_mem (.clk(SYS_CLK), .rst(SRST), .rd(STO_RD), .wr(STO_WR), .addr(STO_ADDR),
    .wdata(STO_WDATA), .lat(lat), .ack(STO_ACK), .rdata(STO_RDATA));
  initial begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  task automatic wrap_up;
    $display("Errors %0d of %0d comparisons", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // Offer one instruction, then wait a bounded time for its done or trap pulse
  task automatic issue(input logic [2:0] s, input logic [14:0] a);
    @(posedge SYS_CLK);
    INSN_VALID <= 1'b1;
    INSN_WORD  <= {dss_pkg::OPC_STATE, s, a};
    @(posedge SYS_CLK);
    INSN_VALID <= 1'b0;
    repeat (40) begin
      #1;
      t = INSN_TRAP;
      d = INSN_DONE;
      if (t || d) return;
      @(posedge SYS_CLK);
    end
    error_cnt++;
    wrap_up();
  endtask : issue
  task automatic reg_acc(input logic w, input logic [1:0] a, input logic [23:0] v);
    @(posedge SYS_CLK);
    REG_ADDR  <= a;
    REG_WDATA <= v;
    REG_WR    <= w;
    REG_RD    <= !w;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
    REG_RD <= 1'b0;
    #1 rd = REG_RDATA;
  endtask : reg_acc
  // Restore each condition code with high addresses and prompt then slow storage
  task automatic s_load;
    logic [1:0] ccs [3] = '{dss_pkg::CC_EQUAL, dss_pkg::CC_FIRST_GT, dss_pkg::CC_FIRST_LT};
    for (int i = 0; i < 3; i++) begin
      img = {12'hA5C, 1'(i > 0), 9'h0AA ^ 9'(i), ccs[i]};
      u_mem.mem[i] = img;
      lat <= 4'(i * 3);
      issue(dss_pkg::SUB_LOAD, 15'h7FF0 + 15'(i));
      `CHK({t, d}, 2'h1)
      `CHK({DEC_COUNT, DEC_FLAGS, DEC_CC}, img)
      `CHK(RESUME, img[11])
    end
  endtask : s_load
  // Store an image fed by the arithmetic side while storage stalls
  task automatic s_store;
    @(posedge SYS_CLK);
    UPD_VALID <= 1'b1;
    UPD_CC    <= 2'h2;
    UPD_FLAGS <= 10'h2C3;
    UPD_COUNT <= 12'h5A1;
    @(posedge SYS_CLK);
    UPD_VALID <= 1'b0;
    lat       <= 4'h5;
    issue(dss_pkg::SUB_STORE, 15'h000A);
    `CHK(u_mem.mem[10], 24'h5A1B0E)
    `CHK({DEC_COUNT, DEC_FLAGS, DEC_CC}, 24'h5A1B0E)
    `CHK(RESUME, 1'b0)
  endtask : s_store
  // Switch off: trap, or no-op in monitor state; a foreign opcode is ignored
  task automatic s_trap;
    ENABLE_SWITCH <= 1'b0;
    for (int j = 0; j < 4; j++) begin
      MONITOR_STATE <= j[1];
      issue(j[0] ? dss_pkg::SUB_STORE : dss_pkg::SUB_LOAD, 15'h0001);
      `CHK({t, d}, {!j[1], j[1]})
    end
    `CHK(DEC_CC, 2'h2)
    ENABLE_SWITCH <= 1'b1;
    MONITOR_STATE <= 1'b0;
    @(posedge SYS_CLK);
    INSN_VALID <= 1'b1;
    INSN_WORD  <= 24'hDF0001;
    @(posedge SYS_CLK);
    INSN_VALID <= 1'b0;
    #1 `CHK({BUSY, STO_RD, INSN_TRAP}, 3'h0)
  endtask : s_trap
  // Mask, raise, clear the interrupt; the spare index reads zero
  task automatic s_irq;
    reg_acc(1'b0, dss_pkg::REG_MASK, 24'h0);
    `CHK({rd, IRQ}, 25'h0)
    reg_acc(1'b1, dss_pkg::REG_MASK, 24'h4);
    `CHK(IRQ, 1'b1)
    reg_acc(1'b0, dss_pkg::REG_STATUS, 24'h0);
    `CHK(rd[2:0], 3'h7)
    reg_acc(1'b1, dss_pkg::REG_STATUS, 24'h7);
    reg_acc(1'b0, dss_pkg::REG_STATE, 24'h0);
    `CHK(rd, 24'h5A1B0E)
    reg_acc(1'b0, 2'h3, 24'h0);
    `CHK({rd, IRQ}, 25'h0)
  endtask : s_irq
  initial begin
    repeat (3) @(posedge SYS_CLK);
    SRST <= 1'b0;
    s_load();
    s_store();
    s_trap();
    s_irq();
    wrap_up();
  end
endmodule : dss_top_test
`default_nettype wire
